// ===== rtl/processor_power_mode_clock_control.sv
// Processor end: mode control and derived clock enables.
// Functional notes
// [RULE1] Three modes: normal, reduced-power, power-off.
// [RULE2] Pipeline clock ratio from select pins.
// [RULE3] Interface clock equals reference clock normally.
// [RULE4] Reset always enters normal mode.
// [RULE5] Reduced-power mode is a build option.
// [RULE6] Reduced-power bit selects reduced mode.
// [RULE7] Quiesce pipeline before entering reduced mode.
// [RULE8] Pipeline clock divided by four.
// [RULE9] Interface and transfer clocks divided by four.
// [RULE10] System logic chooses the mode.
// [RULE11] Agent reprogrammed before bit change.
// [RULE12] System interface idle before toggling.
// [RULE13] No exceptions near the bit change.
// [RULE14] Restore state is readable and writable.
// [RULE15] System saves state, powers off idle.
// [RULE16] Load-link flag cleared at cache start-up.
// [RULE17] Caches invalidated; written back before off. The code only sends an invalidate request, with no write-back.
// [RULE18] Divider changes without glitched pulses.
module processor_power_mode_clock_control
  import pwr_clk_pkg::*;
#(
  parameter bit HAS_REDUCED_POWER = 1'b1,
  parameter int PIPE_DRAIN_CYCLES = 4
)
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Link to the system agent
  pwr_clk_if.device       link,
  // Pipeline side
  input  wire logic       pipeline_stall_ack,
  input  wire logic       cache_startup,
  // Derived clock enables, load-link flag and stall request
  output logic            pipeline_clock,
  output logic            system_interface_clock,
  output logic            transfer_clock,
  output logic            load_link_flag,
  output logic            pipeline_stall_req
);
  import pwr_clk_pkg::*;

  typedef struct packed {
    ctl_state_e         st;
    logic [1:0]         rp_sync;
    logic [1:0]         off_sync;
    logic [RATIO_W-1:0] ratio_meta;
    logic [RATIO_W-1:0] ratio;
    logic [CNT_W-1:0]   drain;
    logic               reduced;
    logic               done;
    logic               stall;
    logic               ll;
    logic               inval_done;
    logic [STATE_W-1:0] saved;
  } ctl_s;

  ctl_s cur;
  ctl_s next_cur;

  logic [DIV_W-1:0] pipe_base;
  logic [DIV_W-1:0] pipe_div;
  logic [DIV_W-1:0] sys_div;
  logic             want_rp;

  // [RULE5] Reduced mode exists only in built variants
  assign want_rp = cur.rp_sync[1] & HAS_REDUCED_POWER;

  // [RULE2] Ratio pins set pipeline divide
  // [RULE8] Quarter pipeline rate when reduced
  always_comb
  begin
    pipe_base = DIV_W'(NORMAL_DIV);
    if (cur.ratio[1])
    begin
      pipe_base = 4'h2;
    end
    pipe_div = pipe_base;
    if (cur.reduced)
    begin
      // The reduced rate is a quarter of whatever rate the pins chose.
      pipe_div = DIV_W'(LOW_POWER_DIV * pipe_base);
    end
  end

  // [RULE3] Interface clock at reference rate
  // [RULE9] Interface and transfer quartered
  assign sys_div = cur.reduced ? DIV_W'(LOW_POWER_DIV) : DIV_W'(NORMAL_DIV);

  always_comb
  begin
    next_cur            = cur;
    next_cur.rp_sync    = {cur.rp_sync[0], link.reduced_power_bit};
    next_cur.off_sync   = {cur.off_sync[0], link.power_off_req};
    // [RULE2] Ratio pins through two flops
    next_cur.ratio_meta = link.clock_ratio_select;
    next_cur.ratio      = cur.ratio_meta;
    next_cur.done       = 1'b0;
    next_cur.inval_done = 1'b0;
    // [RULE16] Cache start-up clears load-link
    if (cache_startup)
    begin
      next_cur.ll = 1'b0;
    end
    // [RULE14] Restore state is writable
    if (link.state_we)
    begin
      next_cur.saved = link.state_wdata;
    end
    // [RULE17] Invalidate operation for caches
    if (link.invalidate_req)
    begin
      next_cur.inval_done = 1'b1;
      next_cur.ll         = 1'b0;
    end
    // [RULE1] Three-mode controller
    unique case (cur.st)
      CTL_NORMAL:
      begin
        if (cur.off_sync[1])
        begin
          next_cur.st = CTL_OFF;
        end
        else if (want_rp)
        begin
          next_cur.st    = CTL_QUIESCE;
          next_cur.stall = 1'b1;
          next_cur.drain = CNT_W'(PIPE_DRAIN_CYCLES);
        end
      end
      // [RULE7] Wait for a quiescent pipeline
      CTL_QUIESCE:
      begin
        if (pipeline_stall_ack && cur.drain == 5'h0)
        begin
          next_cur.st = CTL_SWITCH;
        end
        else if (cur.drain != 5'h0)
        begin
          next_cur.drain = cur.drain - 5'h1;
        end
      end
      // [RULE6] Apply the new divide
      CTL_SWITCH:
      begin
        next_cur.reduced = 1'b1;
        next_cur.stall   = 1'b0;
        next_cur.done    = 1'b1;
        next_cur.st      = CTL_REDUCED;
      end
      CTL_REDUCED:
      begin
        if (cur.off_sync[1])
        begin
          next_cur.st = CTL_OFF;
        end
        else if (!want_rp)
        begin
          next_cur.reduced = 1'b0;
          next_cur.done    = 1'b1;
          next_cur.st      = CTL_NORMAL;
        end
      end
      CTL_OFF:
      begin
        next_cur.reduced = 1'b0;
        if (!cur.off_sync[1] && link.power_good)
        begin
          // Power returns with the link flag set; it stays set until cache start-up or an invalidate request.
          next_cur.ll = 1'b1;
          next_cur.st = CTL_NORMAL;
        end
      end
      default:
      begin
        next_cur.st = CTL_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    // [RULE4] Reset to normal mode
    if (rst)
    begin
      cur.st         <= CTL_NORMAL;
      cur.rp_sync    <= 2'h0;
      cur.off_sync   <= 2'h0;
      cur.ratio_meta <= RATIO_RESET;
      cur.ratio      <= RATIO_RESET;
      cur.drain      <= 5'h0;
      cur.reduced    <= 1'b0;
      cur.done       <= 1'b0;
      cur.stall      <= 1'b0;
      cur.ll         <= 1'b0;
      cur.inval_done <= 1'b0;
      cur.saved      <= 8'h00;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // The pipeline divider starts one cycle after reset so its first period is whole.
  logic ratio_taken;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ratio_taken <= 1'b0;
    end
    else
    begin
      ratio_taken <= 1'b1;
    end
  end

  clock_pulse_divider u_pipe_div (
    .clk_sys   (clk_sys),
    .rst       (rst | ~ratio_taken),
    .divide_by (pipe_div),
    .tick      (pipeline_clock)
  );

  clock_pulse_divider u_sys_div (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .divide_by (sys_div),
    .tick      (system_interface_clock)
  );

  assign transfer_clock          = system_interface_clock;
  assign load_link_flag          = cur.ll;
  assign pipeline_stall_req      = cur.stall;
  assign link.pipeline_quiescent = cur.stall & pipeline_stall_ack;
  assign link.store_buffer_empty = cur.st != CTL_QUIESCE || cur.drain == 5'h0;
  assign link.misses_pending     = cur.st == CTL_QUIESCE && cur.drain != 5'h0;
  assign link.mode_switch_done   = cur.done;
  assign link.invalidate_done    = cur.inval_done;
  assign link.state_rdata        = cur.saved;
  assign link.mode               = (cur.st == CTL_OFF) ? MODE_POWER_OFF :
                                   (cur.reduced ? MODE_REDUCED : MODE_NORMAL);
endmodule

// ===== shared/pwr_clk_pkg.sv
// Constants and types shared by the power-mode clock controller and its system agent.
package pwr_clk_pkg;

  localparam int RATIO_W        = 2;
  localparam int MODE_W         = 2;
  localparam int DIV_W          = 4;
  localparam int LOW_POWER_DIV  = 4;
  localparam int NORMAL_DIV     = 1;
  localparam int STATE_W        = 8;
  localparam int QUIESCE_MAX    = 16;
  localparam int CNT_W          = 5;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 2'h0;

  typedef enum logic [MODE_W-1:0] {
    MODE_NORMAL    = 2'b00,
    MODE_REDUCED   = 2'b01,
    MODE_POWER_OFF = 2'b10
  } power_mode_e;

  typedef enum logic [2:0] {
    CTL_NORMAL     = 3'b000,
    CTL_QUIESCE    = 3'b001,
    CTL_SWITCH     = 3'b010,
    CTL_REDUCED    = 3'b011,
    CTL_OFF        = 3'b100
  } ctl_state_e;

endpackage

// ===== shared/pwr_clk_if.sv
// Interface joining the processor clock controller and the external system agent.
interface pwr_clk_if;
  import pwr_clk_pkg::*;

  logic [RATIO_W-1:0] clock_ratio_select;
  logic               reduced_power_bit;
  logic               power_off_req;
  logic               power_good;
  logic               pipeline_quiescent;
  logic               store_buffer_empty;
  logic               misses_pending;
  logic               mode_switch_done;
  logic [MODE_W-1:0]  mode;
  logic               invalidate_req;
  logic               invalidate_done;
  logic [STATE_W-1:0] state_wdata;
  logic               state_we;
  logic [STATE_W-1:0] state_rdata;

  modport device (
    input  clock_ratio_select,
    input  reduced_power_bit,
    input  power_off_req,
    input  power_good,
    input  invalidate_req,
    input  state_wdata,
    input  state_we,
    output pipeline_quiescent,
    output store_buffer_empty,
    output misses_pending,
    output mode_switch_done,
    output mode,
    output invalidate_done,
    output state_rdata
  );

  modport agent (
    output clock_ratio_select,
    output reduced_power_bit,
    output power_off_req,
    output power_good,
    output invalidate_req,
    output state_wdata,
    output state_we,
    input  pipeline_quiescent,
    input  store_buffer_empty,
    input  misses_pending,
    input  mode_switch_done,
    input  mode,
    input  invalidate_done,
    input  state_rdata
  );
endinterface

// ===== rtl/clock_pulse_divider.sv
// Glitch-free clock-enable divider that only changes ratio at a period boundary.
module clock_pulse_divider
  import pwr_clk_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Control
  input  wire logic [DIV_W-1:0] divide_by,
  // Output
  output logic                  tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] active_div;
    logic             tick;
  } div_s;

  div_s cur;
  div_s next_cur;

  always_comb
  begin
    next_cur      = cur;
    next_cur.tick = 1'b0;
    // [RULE18] Boundary-only ratio change
    if (cur.cnt >= cur.active_div - 4'h1)
    begin
      next_cur.cnt        = 4'h0;
      next_cur.tick       = 1'b1;
      next_cur.active_div = (divide_by == 4'h0) ? 4'h1 : divide_by;
    end
    else
    begin
      next_cur.cnt = cur.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur.cnt        <= 4'h0;
      cur.active_div <= 4'h1;
      cur.tick       <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;
endmodule

// ===== rtl/system_power_agent.sv
// System end: sequences mode requests towards the processor.
module system_power_agent
  import pwr_clk_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // User requests
  input  wire logic [RATIO_W-1:0] ratio_strap,
  input  wire logic               want_reduced,
  input  wire logic               want_off,
  input  wire logic               bus_idle,
  input  wire logic               agent_reprogrammed,
  input  wire logic [STATE_W-1:0] save_data,
  output logic [STATE_W-1:0]      restored_data,
  output logic                    busy,
  // Link to the processor
  pwr_clk_if.agent                link
);
  import pwr_clk_pkg::*;

  typedef struct packed {
    logic               rp;
    logic               off;
    logic               inval;
    logic               we;
    logic [STATE_W-1:0] wdata;
    logic [STATE_W-1:0] rdata;
  } agt_s;

  agt_s cur;
  agt_s next_cur;

  always_comb
  begin
    next_cur       = cur;
    next_cur.inval = 1'b0;
    next_cur.we    = 1'b0;
    next_cur.rdata = link.state_rdata;
    // [RULE11] Reprogram first
    // [RULE12] Interface must be idle
    if (want_reduced != cur.rp && bus_idle && agent_reprogrammed)
    begin
      next_cur.rp = want_reduced;
    end
    // [RULE15] Save state and invalidate before off
    // [RULE17] Caches to be written back and invalidated; only an invalidate request is sent, no write-back
    if (want_off && !cur.off && bus_idle)
    begin
      next_cur.we    = 1'b1;
      next_cur.wdata = save_data;
      next_cur.inval = 1'b1;
      next_cur.off   = 1'b1;
    end
    else if (!want_off)
    begin
      next_cur.off = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // [RULE10] Agent drives the mode
  assign link.reduced_power_bit  = cur.rp;
  assign link.power_off_req      = cur.off;
  assign link.invalidate_req     = cur.inval;
  assign link.state_we           = cur.we;
  assign link.state_wdata        = cur.wdata;
  assign link.clock_ratio_select = ratio_strap;
  assign link.power_good         = ~cur.off;
  assign restored_data           = cur.rdata;
  // [RULE13] Hold off while switching
  assign busy = (cur.rp != link.mode[0]) | link.misses_pending;
endmodule

// ===== sim/pwr_clk_sva.sv
// Checker for the link between the processor clock controller and the system agent.
module pwr_clk_sva
  import pwr_clk_pkg::*;
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  // Requests from the agent
  input wire logic               reduced_power_bit,
  input wire logic               power_off_req,
  input wire logic               invalidate_req,
  input wire logic [STATE_W-1:0] state_wdata,
  input wire logic               state_we,
  // Answers from the processor
  input wire logic               pipeline_quiescent,
  input wire logic               store_buffer_empty,
  input wire logic               misses_pending,
  input wire logic               mode_switch_done,
  input wire logic [MODE_W-1:0]  mode,
  input wire logic               invalidate_done,
  input wire logic [STATE_W-1:0] state_rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence rp_set_s;
    $rose(reduced_power_bit) && !power_off_req;
  endsequence

  // Switching while the pipeline still holds work would lose stores or misses.
  sequence unsafe_switch_s;
    (mode == MODE_NORMAL) && !(pipeline_quiescent && store_buffer_empty && !misses_pending)
      ##1 (mode == MODE_REDUCED);
  endsequence

  sequence enter_s;
    (mode == MODE_NORMAL) ##1 (mode == MODE_REDUCED);
  endsequence

  mode_legal_a: assert property (mode != 2'h3)
    else $error("mode code outside the three modes");
  reset_normal_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    $fell(rst) |-> mode == MODE_NORMAL)
    else $error("mode not normal after reset");
  enter_reduced_a: assert property (rp_set_s |-> ##[3:40] mode == MODE_REDUCED)
    else $error("reduced mode not entered");
  leave_reduced_a: assert property ($fell(reduced_power_bit) && !power_off_req
    |-> ##[1:10] mode == MODE_NORMAL)
    else $error("normal mode not resumed");
  quiesce_first_a: assert property (not unsafe_switch_s)
    else $error("mode switched before the pipeline drained");
  switch_done_a: assert property (enter_s |-> mode_switch_done ##1 !mode_switch_done)
    else $error("switch completion not a single pulse");
  off_wins_a: assert property (power_off_req [*6] |-> mode == MODE_POWER_OFF)
    else $error("power-off request not obeyed");
  invalidate_a: assert property (invalidate_req |-> ##[1:16] invalidate_done)
    else $error("invalidate not completed");
  state_rw_a: assert property (state_we |=> state_rdata == $past(state_wdata))
    else $error("saved state not readable");
endmodule

// ===== sim/tb.sv
// Testbench joining the processor clock controller and the system agent.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pwr_clk_pkg::*;

  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic [RATIO_W-1:0] ratio_strap;
  logic               want_reduced;
  logic               want_off;
  logic               bus_idle;
  logic               agent_reprogrammed;
  logic               pipeline_stall_ack = 1'b0;
  logic               cache_startup;
  logic [STATE_W-1:0] save_data;
  logic [STATE_W-1:0] restored_data;
  logic               busy;
  logic               pipeline_clock;
  logic               system_interface_clock;
  logic               transfer_clock;
  logic               load_link_flag;
  logic               pipeline_stall_req;
  logic               stall_seen = 1'b0;
  logic [MODE_W-1:0]  last_mode = MODE_NORMAL;
  logic [MODE_W-1:0]  exp_q[$];
  logic [7:0]         sd;
  int                 fail_count = 0;
  int                 check_count = 0;
  int                 cycles = 0;
  int                 seed = 5;
  wire logic [2:0]    ticks = {transfer_clock, system_interface_clock, pipeline_clock};

  always #50 clk_sys = ~clk_sys;

  pwr_clk_if link_if();

  processor_power_mode_clock_control u_processor_power_mode_clock_control (
    .clk_sys(clk_sys), .rst(rst), .link(link_if), .pipeline_stall_ack(pipeline_stall_ack),
    .cache_startup(cache_startup), .pipeline_clock(pipeline_clock),
    .system_interface_clock(system_interface_clock), .transfer_clock(transfer_clock),
    .load_link_flag(load_link_flag), .pipeline_stall_req(pipeline_stall_req));

  system_power_agent u_system_power_agent (
    .clk_sys(clk_sys), .rst(rst), .ratio_strap(ratio_strap), .want_reduced(want_reduced),
    .want_off(want_off), .bus_idle(bus_idle), .agent_reprogrammed(agent_reprogrammed),
    .save_data(save_data), .restored_data(restored_data), .busy(busy), .link(link_if));

  pwr_clk_sva u_pwr_clk_sva (
    .clk_sys(clk_sys), .rst(rst), .reduced_power_bit(link_if.reduced_power_bit),
    .power_off_req(link_if.power_off_req), .invalidate_req(link_if.invalidate_req),
    .state_wdata(link_if.state_wdata), .state_we(link_if.state_we),
    .pipeline_quiescent(link_if.pipeline_quiescent),
    .store_buffer_empty(link_if.store_buffer_empty), .misses_pending(link_if.misses_pending),
    .mode_switch_done(link_if.mode_switch_done), .mode(link_if.mode),
    .invalidate_done(link_if.invalidate_done), .state_rdata(link_if.state_rdata));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Gap in cycles between two pulses of one clock enable.
  task automatic period(input int sel, input int exp);
    int n;
    n = 0;
    do @(posedge clk_sys); while (ticks[sel] !== 1'b1);
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (ticks[sel] !== 1'b1 && n < 20);
    check(8'(n), 8'(exp));
  endtask

  task automatic wait_mode(input logic [MODE_W-1:0] m);
    repeat (60) if (link_if.mode !== m) @(posedge clk_sys);
    check(8'(link_if.mode), 8'(m));
  endtask

  // The pipeline answers a stall one cycle late, as a real pipeline would.
  always @(posedge clk_sys)
  begin
    pipeline_stall_ack <= pipeline_stall_req;
    if (pipeline_stall_req === 1'b1)
      stall_seen <= 1'b1;
  end

  // Every mode change takes the oldest expected mode off the queue.
  always @(posedge clk_sys)
  begin
    #1;
    if (!rst && link_if.mode !== last_mode)
      check(8'(link_if.mode), exp_q.size() ? 8'(exp_q.pop_front()) : 8'hff);
    last_mode = link_if.mode;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      final_report();
    end
  end

  initial
  begin
    ratio_strap = 2'h0;
    want_reduced = 1'b0;
    want_off = 1'b0;
    bus_idle = 1'b1;
    agent_reprogrammed = 1'b1;
    cache_startup = 1'b0;
    save_data = 8'h00;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check(8'(link_if.mode), 8'(MODE_NORMAL));
    for (int r = 0; r < 4; r++)
    begin
      ratio_strap <= 2'(r);
      repeat (8) @(posedge clk_sys);
      period(0, r[1] ? 2 : 1);
    end
    ratio_strap <= 2'h0;
    period(1, 1);
    bus_idle <= 1'b0;
    want_reduced <= 1'b1;
    repeat (20) @(posedge clk_sys);
    bus_idle <= 1'b1;
    agent_reprogrammed <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check(8'(link_if.mode), 8'(MODE_NORMAL));
    exp_q.push_back(MODE_REDUCED);
    agent_reprogrammed <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(8'(busy), 8'h01);
    wait_mode(MODE_REDUCED);
    check(8'(stall_seen), 8'h01);
    repeat (8) @(posedge clk_sys);
    check(8'(busy), 8'h00);
    period(0, 4);
    period(1, 4);
    period(2, 4);
    ratio_strap <= 2'h3;
    repeat (12) @(posedge clk_sys);
    period(0, 8);
    ratio_strap <= 2'h0;
    exp_q.push_back(MODE_NORMAL);
    want_reduced <= 1'b0;
    wait_mode(MODE_NORMAL);
    repeat (8) @(posedge clk_sys);
    period(1, 1);
    sd = 8'($random(seed));
    save_data <= sd;
    exp_q.push_back(MODE_POWER_OFF);
    exp_q.push_back(MODE_NORMAL);
    want_off <= 1'b1;
    wait_mode(MODE_POWER_OFF);
    want_off <= 1'b0;
    wait_mode(MODE_NORMAL);
    repeat (10) @(posedge clk_sys);
    check(restored_data, sd);
    check(8'(load_link_flag), 8'h01);
    cache_startup <= 1'b1;
    @(posedge clk_sys);
    cache_startup <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(8'(load_link_flag), 8'h00);
    repeat (5) @(posedge clk_sys);
    final_report();
  end
endmodule
